// ### hw/sac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"
module sac_top #(
   parameter int FRAME_BITS = `SAC_FRAME_BITS
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic SER_CLK,
   input wire logic FRAME_EN_N,
   input wire logic SER_DIN,
   output logic SER_DOUT,
   output logic [7:0] CH1_CODE,
   output logic [7:0] CH2_CODE,
   output logic CH1_MUTE,
   output logic CH2_MUTE,
   output logic [8:0] CH1_ATTEN_HALF_DB,
   output logic [8:0] CH2_ATTEN_HALF_DB,
   output logic FRAME_DONE
);
   // ****************************************
   // Pin synchronisation
   // ****************************************
   logic [2:0] pins_sync;
   logic sclk_s;
   logic en_n_s;
   logic din_s;
   logic sclk_d;
   logic en_n_d;
   logic sclk_rise;
   logic en_rise;
   sac_sync #(
      .WIDTH(3),
      .INIT(3'h2)
   ) u_sync (
      .clk(MCLK),
      .rst(RST),
      .din({SER_CLK, FRAME_EN_N, SER_DIN}),
      .dout(pins_sync)
   );
   assign sclk_s = pins_sync[2];
   assign en_n_s = pins_sync[1];
   assign din_s = pins_sync[0];

   // Edge history, reset idle: enable high
   always_ff @(posedge MCLK) begin
      if (RST) begin
         sclk_d <= 1'b0;
         en_n_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         en_n_d <= en_n_s;
      end
   end
   assign sclk_rise = sclk_s & ~sclk_d;
   assign en_rise = en_n_s & ~en_n_d;

   // ****************************************
   // Shift register and chain output
   // ****************************************
   logic [FRAME_BITS-1:0] shreg;
   logic shift_ok;
   // Enable low gates the shift; high freezes the shift register and chain output
   assign shift_ok = sclk_rise & ~en_n_s;

   // New bit enters at LSB so the first bit ends up as MSB
   always_ff @(posedge MCLK) begin
      if (RST) begin
         shreg <= `SAC_RESET_SHIFT;
      end else if (shift_ok) begin
         shreg <= {shreg[FRAME_BITS-2:0], din_s};
      end
   end

   // MSB falls out as the new bit arrives, feeding the next device
   always_ff @(posedge MCLK) begin
      if (RST) begin
         SER_DOUT <= 1'b0;
      end else if (shift_ok) begin
         SER_DOUT <= shreg[FRAME_BITS-1];
      end
   end

   // ****************************************
   // Latch and decode
   // ****************************************
   logic [7:0] addr_byte;
   logic [7:0] code_byte;
   assign addr_byte = shreg[`SAC_ADDR_MSB:`SAC_ADDR_LSB];
   assign code_byte = shreg[`SAC_CODE_MSB:`SAC_CODE_LSB];

   // Half-dB units: fine range linear, coarse adds 2 per code, mute parked at 200
   function automatic logic [8:0] sac_half_db(input logic [7:0] code);
      logic [8:0] c;
      c = {1'b0, code};
      if (code >= `SAC_CODE_MUTE) begin
         sac_half_db = `SAC_MUTE_HALF_DB;
      end else if (code >= `SAC_CODE_COARSE) begin
         sac_half_db = 9'(c + c - 9'h060);
      end else begin
         sac_half_db = c;
      end
   endfunction

   function automatic sac_pkg::sac_range_t sac_range(input logic [7:0] code);
      if (code >= `SAC_CODE_MUTE) begin
         sac_range = sac_pkg::SAC_MUTED;
      end else if (code >= `SAC_CODE_COARSE) begin
         sac_range = sac_pkg::SAC_COARSE;
      end else begin
         sac_range = sac_pkg::SAC_FINE;
      end
   endfunction

   // Receive progress, mainly for observation
   sac_pkg::sac_state_t state;
   always_ff @(posedge MCLK) begin
      if (RST) begin
         state <= sac_pkg::SAC_IDLE;
      end else begin
         case (state)
            sac_pkg::SAC_IDLE: begin
               if (!en_n_s) begin
                  state <= sac_pkg::SAC_SHIFT;
               end
            end
            sac_pkg::SAC_SHIFT: begin
               if (en_rise) begin
                  state <= sac_pkg::SAC_LATCH;
               end
            end
            sac_pkg::SAC_LATCH: begin
               state <= sac_pkg::SAC_IDLE;
            end
            default: begin
               state <= sac_pkg::SAC_IDLE;
            end
         endcase
      end
   end

   // Channel one; third address has no ladder here, so it is a no-op
   always_ff @(posedge MCLK) begin
      if (RST) begin
         CH1_CODE <= `SAC_RESET_CODE;
      end else if (en_rise && addr_byte == `SAC_ADDR_CH1) begin
         CH1_CODE <= code_byte;
      end
   end

   // Channel two
   always_ff @(posedge MCLK) begin
      if (RST) begin
         CH2_CODE <= `SAC_RESET_CODE;
      end else if (en_rise && addr_byte == `SAC_ADDR_CH2) begin
         CH2_CODE <= code_byte;
      end
   end

   // Decoded outputs registered for clean levels
   always_ff @(posedge MCLK) begin
      if (RST) begin
         CH1_MUTE <= 1'b1;
         CH2_MUTE <= 1'b1;
         CH1_ATTEN_HALF_DB <= `SAC_MUTE_HALF_DB;
         CH2_ATTEN_HALF_DB <= `SAC_MUTE_HALF_DB;
      end else begin
         CH1_MUTE <= (sac_range(CH1_CODE) == sac_pkg::SAC_MUTED);
         CH2_MUTE <= (sac_range(CH2_CODE) == sac_pkg::SAC_MUTED);
         CH1_ATTEN_HALF_DB <= sac_half_db(CH1_CODE);
         CH2_ATTEN_HALF_DB <= sac_half_db(CH2_CODE);
      end
   end

   // One pulse per latched frame, addressed to us or not
   always_ff @(posedge MCLK) begin
      if (RST) begin
         FRAME_DONE <= 1'b0;
      end else begin
         FRAME_DONE <= en_rise;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence shift_ev;
      shift_ok;
   endsequence
   sequence latch_ev;
      en_rise;
   endsequence

   shift_in_a: assert property (@(posedge MCLK) disable iff (RST)
      shift_ev |=> shreg[0] == $past(din_s))
      else $error("shift register missed input bit");
   hold_high_a: assert property (@(posedge MCLK) disable iff (RST)
      en_n_s && !en_rise |=> $stable(shreg))
      else $error("shift register moved while enable high");
   gate_en_a: assert property (@(posedge MCLK) disable iff (RST)
      !shift_ok |=> $stable(SER_DOUT))
      else $error("chain output moved without a shift");
   chain_out_a: assert property (@(posedge MCLK) disable iff (RST)
      shift_ev |=> SER_DOUT == $past(shreg[FRAME_BITS-1]))
      else $error("chain output not old MSB");
   ch1_load_a: assert property (@(posedge MCLK) disable iff (RST)
      latch_ev and (addr_byte == `SAC_ADDR_CH1) |=> CH1_CODE == $past(code_byte))
      else $error("channel one not loaded");
   ch2_keep_a: assert property (@(posedge MCLK) disable iff (RST)
      !(en_rise && addr_byte == `SAC_ADDR_CH2) |=> $stable(CH2_CODE))
      else $error("channel two disturbed");
   bad_addr_a: assert property (@(posedge MCLK) disable iff (RST)
      latch_ev and (addr_byte > `SAC_ADDR_CH2) |=> $stable(CH1_CODE) && $stable(CH2_CODE))
      else $error("unknown address changed a channel");
   mute_code_a: assert property (@(posedge MCLK) disable iff (RST)
      CH1_CODE >= `SAC_CODE_MUTE |=> CH1_MUTE)
      else $error("mute code did not mute");
   coarse_step_a: assert property (@(posedge MCLK) disable iff (RST)
      CH2_CODE == `SAC_CODE_COARSE |=> CH2_ATTEN_HALF_DB == 9'h060)
      else $error("48 dB point wrong");
   reset_mute_a: assert property (@(posedge MCLK)
      $fell(RST) |-> CH1_MUTE && CH2_MUTE && CH1_CODE == `SAC_RESET_CODE)
      else $error("channels not muted after reset");
   // A legal latch always follows a shift phase; a glitchy enable trips this
   frame_track_a: assert property (@(posedge MCLK) disable iff (RST)
      latch_ev |-> state == sac_pkg::SAC_SHIFT ##1 state == sac_pkg::SAC_LATCH)
      else $error("latch without a shift phase");
endmodule
`default_nettype wire

// ### hw/sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// Frame layout
`define SAC_FRAME_BITS 16
`define SAC_BYTE_BITS 8
`define SAC_ADDR_MSB 15
`define SAC_ADDR_LSB 8
`define SAC_CODE_MSB 7
`define SAC_CODE_LSB 0
// Channel addresses
`define SAC_ADDR_CH1 8'h00
`define SAC_ADDR_CH2 8'h01
`define SAC_ADDR_CH3 8'h02
// Attenuation code boundaries
`define SAC_CODE_COARSE 8'h60
`define SAC_CODE_MUTE 8'h7F
// Reset values: muted, code parked at mute
`define SAC_RESET_CODE 8'h7F
`define SAC_RESET_SHIFT 16'h0000
// Attenuation reported for a muted channel, in half-dB units
`define SAC_MUTE_HALF_DB 9'h0C8
// Host setup time before the first clock edge, in ns
`define SAC_SETUP_NS 150
`define SAC_CLK_PERIOD_NS 20
`define SAC_SETUP_CYCLES ((`SAC_SETUP_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`endif

// ### hw/sac_pkg.sv
`default_nettype none
package sac_pkg;
   // Decoded setting of one channel
   typedef enum logic [1:0] {
      SAC_FINE,
      SAC_COARSE,
      SAC_MUTED
   } sac_range_t;
   // Frame receive progress
   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_SHIFT,
      SAC_LATCH
   } sac_state_t;
endpackage
`default_nettype wire

// ### hw/sac_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser; first stage feeds only the second
module sac_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;
   // Both stages reset to a safe level
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= INIT;
         dout <= INIT;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

// ### testbench/sac_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host controller
// ****************
module sac_host (
   input wire logic MCLK,
   input wire logic SER_DOUT,
   output logic SER_CLK,
   output logic FRAME_EN_N,
   output logic SER_DIN
);
   logic [31:0] got;
   // Idle link: clock low, enable high
   initial begin
      SER_CLK = 1'b0;
      FRAME_EN_N = 1'b1;
      SER_DIN = 1'b0;
      got = 32'h0;
   end
   // Pins move a fixed delay after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge MCLK);
      #2;
   endtask
   // Shift n bits MSB first, sampling the chain output per bit
   task automatic frame(input logic [31:0] w, input int n);
      got = 32'h0;
      FRAME_EN_N = 1'b0;
      tick(8);
      for (int i = n - 1; i >= 0; i--) begin
         SER_DIN = w[i];
         tick(4);
         SER_CLK = 1'b1;
         tick(4);
         SER_CLK = 1'b0;
         tick(2);
         SER_DIN = ~w[i]; // Stale data never looks valid
         tick(2);
         got = {got[30:0], SER_DOUT};
      end
      FRAME_EN_N = 1'b1;
      tick(4);
   endtask
   // Clock pulses with enable high, which must be ignored
   task automatic stray();
      for (int i = 0; i < 3; i++) begin
         SER_DIN = i[0];
         tick(4);
         SER_CLK = 1'b1;
         tick(4);
         SER_CLK = 1'b0;
         tick(4);
      end
   endtask
endmodule
`default_nettype wire

// ### testbench/serial_attenuator_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define SAC_CHK(g, e, m) begin \
   checks++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("wrong value at %0t: %s", $time, m); \
   end \
end
module serial_attenuator_control_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   wire logic ser_clk, frame_en_n, ser_din;
   logic ser_dout, ch1_mute, ch2_mute, fdone;
   logic [7:0] ch1_code, ch2_code, e1, e2;
   logic [8:0] ch1_atten, ch2_atten;
   logic [15:0] q[$];
   logic [15:0] note, last;
   logic [7:0] codes[9] = '{8'h00, 8'h01, 8'h5F, 8'h60, 8'h61, 8'h7E, 8'h7F, 8'h80, 8'hFF};
   logic [7:0] addrs[4] = '{8'h02, 8'h03, 8'h80, 8'hFF};
   int error_cnt = 0;
   int checks = 0;
   always #10 mclk = ~mclk;
   sac_top #(.FRAME_BITS(16)) u_dut (.MCLK(mclk), .RST(rst), .SER_CLK(ser_clk), .FRAME_EN_N(frame_en_n),
      .SER_DIN(ser_din), .SER_DOUT(ser_dout), .CH1_CODE(ch1_code), .CH2_CODE(ch2_code), .CH1_MUTE(ch1_mute),
      .CH2_MUTE(ch2_mute), .CH1_ATTEN_HALF_DB(ch1_atten), .CH2_ATTEN_HALF_DB(ch2_atten), .FRAME_DONE(fdone));
   sac_host u_host (.MCLK(mclk), .SER_DOUT(ser_dout), .SER_CLK(ser_clk), .FRAME_EN_N(frame_en_n),
      .SER_DIN(ser_din));
   // Expected attenuation in half-dB
   function automatic logic [8:0] half_db(input logic [7:0] c);
      if (c >= 8'h7F) return 9'h0C8;
      if (c >= 8'h60) return {c, 1'b0} - 9'h060;
      return {1'b0, c};
   endfunction
   task automatic close_out();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Note the expected settings, send, check what fell out
   task automatic send(input logic [31:0] w, input int n);
      logic [31:0] exp_out;
      exp_out = (n == 32) ? {last, w[31:16]} : {16'h0000, last};
      if (w[15:8] == 8'h00) e1 = w[7:0];
      else if (w[15:8] == 8'h01) e2 = w[7:0];
      q.push_back({e1, e2});
      u_host.frame(w, n);
      `SAC_CHK(u_host.got, exp_out, "chain output")
      last = w[15:0];
   endtask
   // ****************
   // Result monitor
   // ****************
   // Falling edge sampling keeps clear of the edge that launches the outputs
   initial forever begin
      @(negedge mclk);
      if (fdone === 1'b1) begin
         if (q.size() == 0) `SAC_CHK(1'b1, 1'b0, "unexpected frame done")
         else begin
            note = q.pop_front();
            @(negedge mclk); // Mute and attenuation settle one cycle after the code
            `SAC_CHK({ch1_code, ch2_code}, note, "channel codes")
            `SAC_CHK({ch1_mute, ch2_mute}, {note[15:8] >= 8'h7F, note[7:0] >= 8'h7F}, "mute")
            `SAC_CHK({ch1_atten, ch2_atten}, {half_db(note[15:8]), half_db(note[7:0])}, "atten")
         end
      end
   end
   // Hang guard
   initial begin
      repeat (40000) @(posedge mclk);
      error_cnt++;
      close_out();
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      void'($urandom(32'hCF5D));
      e1 = 8'h7F;
      e2 = 8'h7F;
      last = 16'h0000;
      repeat (3) @(posedge mclk);
      #2 rst = 1'b0;
      @(posedge mclk);
      #2;
      `SAC_CHK({ch1_code, ch2_code, ch1_mute, ch2_mute}, {16'h7F7F, 2'b11}, "reset codes")
      `SAC_CHK({ch1_atten, ch2_atten}, {9'h0C8, 9'h0C8}, "reset atten")
      foreach (codes[i]) send({16'h0000, 7'h00, i[0], codes[i]}, 16);
      foreach (addrs[i]) send({16'h0000, addrs[i], 8'h10}, 16);
      repeat (4) send({16'h0000, 7'h00, 1'($urandom), 8'($urandom)}, 16);
      u_host.stray();
      send({16'h0000, 16'h0122}, 16);
      send({16'h0033, 16'h0120}, 32);
      for (int k = 0; k < 50 && q.size() > 0; k++) @(posedge mclk);
      `SAC_CHK(q.size(), 0, "results missing")
      close_out();
   end
endmodule
`default_nettype wire
